// file: hdl/safety_alarm_fault_timing.sv
// Safety monitor: alarm flags, whole-word flag clearing, fault-state timing

// ************************************************************
// Module
// ************************************************************
// What this block does
// - Partial writes may clear other flags
// - Status register: one bits clear flags
// - Recovery registers: zero bits clear flags
// - Alarm action independent of flag clearing
// - Alarm seven bits 1,0 set after reset
// - Clock-off fault undetectable in bistable mode
// - Fault time equals period times (value+1)
// - Low fault-time field fixed all ones
module safety_alarm_fault_timing (
   input  wire logic                                  clk,
   input  wire logic                                  rst_b,
   input  wire safety_monitor_pkg::flag_write_type    flag_wr,
   input  wire logic [31:0]                           status_events,
   input  wire logic [31:0]                           recovery_events,
   input  wire logic [31:0]                           alarm7_events,
   input  wire logic                                  hidden_src_clear,
   input  wire logic                                  alarm_trigger,
   input  wire logic [3:0]                            fault_time_high_field,
   input  wire safety_monitor_pkg::protocol_type      fault_signal_protocol,
   input  wire logic                                  core_enable,
   output logic [31:0]                                alarm_status_group_zero,
   output logic [31:0]                                recovery_miss_error_flags,
   output logic [31:0]                                recovery_status,
   output logic [31:0]                                alarm_group_seven,
   output logic [17:0]                                fault_time_value,
   output logic                                       fault_active,
   output logic                                       core_off_detectable
);

   // ************************************************************
   // Input synchronisers for asynchronous event and trigger lines
   // ************************************************************
   logic [31:0] st_s1;
   logic [31:0] st_s2;
   logic [31:0] rc_s1;
   logic [31:0] rc_s2;
   logic [31:0] a7_s1;
   logic [31:0] a7_s2;
   logic        trg_s1;
   logic        trg_s2;
   logic        src_s1;
   logic        src_s2;

   // Two stages per line; logic reads only the second stage, so a
   // metastable first stage never reaches the flags
   always_ff @(posedge clk) begin
      st_s1 <= status_events;
      st_s2 <= st_s1;
   end

   always_ff @(posedge clk) begin
      rc_s1 <= recovery_events;
      rc_s2 <= rc_s1;
   end

   always_ff @(posedge clk) begin
      a7_s1 <= alarm7_events;
      a7_s2 <= a7_s1;
   end

   always_ff @(posedge clk) begin
      trg_s1 <= alarm_trigger;
      trg_s2 <= trg_s1;
   end

   always_ff @(posedge clk) begin
      src_s1 <= hidden_src_clear;
      src_s2 <= src_s1;
   end

   // ************************************************************
   // Flag clearing
   // ************************************************************
   // Set wins over clear so an event in the clearing cycle survives
   function automatic logic [31:0] update(
      input logic [31:0] cur,
      input logic [31:0] set,
      input logic        wr,
      input logic [31:0] clr_mask
   );
      update = (wr ? (cur & ~clr_mask) : cur) | set;
   endfunction

   // Only whole words arrive here; no byte masks exist
   // A masked modify writing back read flags clears them all in the status register,
   // since every strobe is taken as a full word
   wire [31:0] status_clr   = flag_wr.data;
   wire [31:0] recovery_clr = ~flag_wr.data;
   // Alarm seven holds until its hidden source is cleared
   wire        a7_clr_ok    = src_s2;
   wire [31:0] a7_clr       = a7_clr_ok ? flag_wr.data
                                        : safety_monitor_pkg::ZERO_WORD;

   wire [31:0] next_status =
      update(alarm_status_group_zero, st_s2, flag_wr.status_wr, status_clr);
   wire [31:0] next_rec_err =
      update(recovery_miss_error_flags, rc_s2, flag_wr.recovery_err_wr,
             recovery_clr);
   wire [31:0] next_rsts =
      update(recovery_status, rc_s2, flag_wr.recovery_sts_wr, recovery_clr);
   wire [31:0] next_alarm_group_seven =
      update(alarm_group_seven, a7_s2, flag_wr.alarm7_wr, a7_clr);

   // One edge from strobe to flag; an event in that edge still sets
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         alarm_status_group_zero   <= safety_monitor_pkg::ZERO_WORD;
         recovery_miss_error_flags <= safety_monitor_pkg::ZERO_WORD;
         recovery_status           <= safety_monitor_pkg::ZERO_WORD;
         alarm_group_seven         <= safety_monitor_pkg::ALARM7_RESET;
      end else begin
         alarm_status_group_zero   <= next_status;
         recovery_miss_error_flags <= next_rec_err;
         recovery_status           <= next_rsts;
         alarm_group_seven         <= next_alarm_group_seven;
      end
   end

   // ************************************************************
   // Fault-state timing
   // ************************************************************
   // High field placed directly above the hardwired low field
   function automatic logic [17:0] join_time(
      input logic [3:0] high
   );
      join_time = {high, safety_monitor_pkg::FAULT_TIME_LOW};
   endfunction

   wire [17:0] next_ft_value = join_time(fault_time_high_field);
   // Cycles = ref period cycles * (value + 1)
   localparam logic [7:0] REF_LAST = 8'(safety_monitor_pkg::REF_CYCLES - 1);

   safety_monitor_pkg::fault_state_type state;
   safety_monitor_pkg::fault_state_type next_state;
   logic [7:0]  pre_cnt;
   logic [7:0]  next_pre_cnt;
   logic [17:0] per_cnt;
   logic [17:0] next_per_cnt;
   logic [17:0] next_ft_hold;
   wire         ref_tick  = (pre_cnt == REF_LAST);
   wire         time_done = ref_tick && (per_cnt == fault_time_value);

   // Reaction depends only on the trigger and the fault timer, never on flag writes
   always_comb begin
      next_state   = state;
      next_pre_cnt = pre_cnt;
      next_per_cnt = per_cnt;
      next_ft_hold = fault_time_value;
      case (state)
         safety_monitor_pkg::FS_IDLE: begin
            // Timing field taken only while idle, so a running fault
            // keeps the length it started with
            next_ft_hold = next_ft_value;
            next_pre_cnt = 8'h00;
            next_per_cnt = 18'h00000;
            if (trg_s2) begin
               next_state = safety_monitor_pkg::FS_FAULT;
            end
         end
         safety_monitor_pkg::FS_FAULT: begin
            next_pre_cnt = ref_tick ? 8'h00 : pre_cnt + 8'h01;
            // Count parks at the end value while the trigger persists
            if (ref_tick && !time_done) begin
               next_per_cnt = per_cnt + 18'h00001;
            end
            if (time_done && !trg_s2) begin
               next_state = safety_monitor_pkg::FS_IDLE;
            end
         end
         default: begin
            next_state = safety_monitor_pkg::FS_IDLE;
         end
      endcase
   end

   wire next_fault_active = (next_state == safety_monitor_pkg::FS_FAULT);

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         state            <= safety_monitor_pkg::FS_IDLE;
         pre_cnt          <= 8'h00;
         per_cnt          <= 18'h00000;
         fault_time_value <= join_time(safety_monitor_pkg::HIGH_RESET);
         fault_active     <= 1'b0;
      end else begin
         state            <= next_state;
         pre_cnt          <= next_pre_cnt;
         per_cnt          <= next_per_cnt;
         fault_time_value <= next_ft_hold;
         fault_active     <= next_fault_active;
      end
   end

   // ************************************************************
   // Core shutdown visibility
   // ************************************************************
   // Only dynamic protocols toggle, so a dead core shows on the pins;
   // bistable and unused modes leave software polling as the only guard
   wire dynamic_proto =
      (fault_signal_protocol == safety_monitor_pkg::PROTO_DUAL_RAIL) ||
      (fault_signal_protocol == safety_monitor_pkg::PROTO_TIME_SWITCH);
   wire next_detectable = core_enable && dynamic_proto;

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         core_off_detectable <= 1'b0;
      end else begin
         core_off_detectable <= next_detectable;
      end
   end

endmodule

// file: shared/safety_monitor_pkg.sv
// Package: constants and carriers for the safety monitor flag and fault logic
package safety_monitor_pkg;

   // ************************************************************
   // Widths and positions
   // ************************************************************
   localparam int FLAG_W     = 32;
   localparam int LOW_W      = 14;
   localparam int HIGH_W     = 4;
   localparam int FT_W       = LOW_W + HIGH_W;
   localparam int A7_BIT0    = 0;
   localparam int A7_BIT1    = 1;

   // ************************************************************
   // Reset values and fixed fields
   // ************************************************************
   localparam logic [LOW_W-1:0]  FAULT_TIME_LOW  = 14'h3FFF;
   localparam logic [HIGH_W-1:0] HIGH_RESET      = 4'h0;
   localparam logic [31:0]       ALARM7_RESET    = 32'h00000003;
   localparam logic [31:0]       ZERO_WORD       = 32'h00000000;
   localparam logic [31:0]       ONES_WORD       = 32'hFFFFFFFF;

   // ************************************************************
   // Timing: fault-state reference period
   // ************************************************************
   localparam int CLK_NS       = 50;
   localparam int REF_PERIOD_NS = 50;
   localparam int REF_CYCLES   = (REF_PERIOD_NS + CLK_NS - 1) / CLK_NS;
   localparam int PRE_W        = 8;

   typedef enum logic [1:0] {
      PROTO_NONE,
      PROTO_BISTABLE,
      PROTO_DUAL_RAIL,
      PROTO_TIME_SWITCH
   } protocol_type;

   typedef enum {
      FS_IDLE,
      FS_FAULT
   } fault_state_type;

   // Whole-word write to one of the flag registers
   typedef struct packed {
      logic        status_wr;
      logic        recovery_err_wr;
      logic        recovery_sts_wr;
      logic        alarm7_wr;
      logic [31:0] data;
   } flag_write_type;

endpackage

// file: tb/safety_alarm_fault_timing_properties.sv
// Checker: flag clearing and fault timing of the safety monitor
module safety_alarm_fault_timing_properties (
   input wire logic                               clk,
   input wire logic                               rst_b,
   input wire safety_monitor_pkg::flag_write_type flag_wr,
   input wire logic [31:0]                        status_events,
   input wire logic                               alarm_trigger,
   input wire logic [3:0]                         fault_time_high_field,
   input wire safety_monitor_pkg::protocol_type   fault_signal_protocol,
   input wire logic                               core_enable,
   input wire logic [31:0]                        alarm_status_group_zero,
   input wire logic [31:0]                        alarm_group_seven,
   input wire logic [17:0]                        fault_time_value,
   input wire logic                               fault_active,
   input wire logic                               core_off_detectable
);
   timeunit 1ns;
   timeprecision 1ns;
   // ***********************************
   // Properties
   // ***********************************
   default clocking @(posedge clk);
   endclocking
   default disable iff (!rst_b);
   // Length of the current fault, in cycles
   int unsigned run;
   always_ff @(posedge clk) run <= fault_active ? run + 1 : 0;
   // Synced events could set a flag in the clearing cycle
   sequence st_quiet; (status_events == 32'h0)[*4]; endsequence
   sequence st_clear; st_quiet ##0 flag_wr.status_wr; endsequence
   a_status_keep: assert property (flag_wr.status_wr |=>
      ($past(alarm_status_group_zero) & ~$past(flag_wr.data)
      & ~alarm_status_group_zero) == 32'h0) else $error("flag lost");
   a_status_clear: assert property (st_clear |=>
      (alarm_status_group_zero & $past(flag_wr.data)) == 32'h0)
      else $error("flag not cleared");
   a_alarm_seven_reset: assert property ($rose(rst_b) |->
      alarm_group_seven == safety_monitor_pkg::ALARM7_RESET)
      else $error("alarm seven reset");
   a_low_fixed: assert property (
      fault_time_value[13:0] == 14'h3FFF) else $error("low field");
   a_value_concat: assert property (
      $past(rst_b) && !$past(fault_active) |-> fault_time_value ==
      {$past(fault_time_high_field), 14'h3FFF}) else $error("concat");
   a_fault_min_time: assert property ($fell(fault_active) |->
      run >= safety_monitor_pkg::REF_CYCLES * (fault_time_value + 1))
      else $error("fault too short");
   a_fault_start: assert property (
      $rose(alarm_trigger) && !fault_active |-> ##[2:4] fault_active)
      else $error("no fault");
   a_core_off_seen: assert property ($past(rst_b) |->
      core_off_detectable == ($past(core_enable) &&
      ($past(fault_signal_protocol) == safety_monitor_pkg::PROTO_DUAL_RAIL
      || $past(fault_signal_protocol) ==
      safety_monitor_pkg::PROTO_TIME_SWITCH))) else $error("detectable");
endmodule
bind safety_alarm_fault_timing safety_alarm_fault_timing_properties
   chk_i (.clk, .rst_b, .flag_wr, .status_events, .alarm_trigger,
   .fault_time_high_field, .fault_signal_protocol, .core_enable,
   .alarm_status_group_zero, .alarm_group_seven, .fault_time_value,
   .fault_active, .core_off_detectable);

// file: tb/tb_safety_alarm_fault_timing.sv
// Testbench: flag clearing, reset alarms and fault-state timing
module tb_safety_alarm_fault_timing;
   timeunit 1ns;
   timeprecision 1ns;
   // ***********************************
   // Stimulus and checks
   // ***********************************
   logic                               clk = 1'h0;
   logic                               rst_b = 1'h0;
   safety_monitor_pkg::flag_write_type flag_wr = '0;
   logic [31:0]                        status_events = 32'h0;
   logic [31:0]                        recovery_events = 32'h0;
   logic [31:0]                        alarm7_events = 32'h0;
   logic                               hidden_src_clear = 1'h0;
   logic                               alarm_trigger = 1'h0;
   logic [3:0]                         fault_time_high_field = 4'h0;
   safety_monitor_pkg::protocol_type   fault_signal_protocol =
      safety_monitor_pkg::PROTO_NONE;
   logic                               core_enable = 1'h0;
   logic [31:0]                        alarm_status_group_zero;
   logic [31:0]                        recovery_miss_error_flags;
   logic [31:0]                        recovery_status;
   logic [31:0]                        alarm_group_seven;
   logic [17:0]                        fault_time_value;
   logic                               fault_active;
   logic                               core_off_detectable;
   int                                 n_mismatch = 0;
   int                                 n_checks = 0;
   int                                 n;
   safety_alarm_fault_timing uut (.clk, .rst_b, .flag_wr, .status_events,
      .recovery_events, .alarm7_events, .hidden_src_clear, .alarm_trigger,
      .fault_time_high_field, .fault_signal_protocol, .core_enable,
      .alarm_status_group_zero, .recovery_miss_error_flags,
      .recovery_status, .alarm_group_seven, .fault_time_value,
      .fault_active, .core_off_detectable);
   always #25 clk = ~clk;
   task automatic tick(input int k);
      repeat (k) @(negedge clk);
   endtask
   // Whole-word strobe: k 0 status, 1 error, 2 recovery status, 3 alarm
   task automatic wr(input int k, input logic [31:0] d);
      @(negedge clk);
      flag_wr = {4'h8 >> k, d};
      @(negedge clk);
      flag_wr = {4'h0, d};
   endtask
   task automatic chk(input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("[ERR] t=%0t exp=%h got=%h", $time, e, g);
      end
   endtask
   task automatic tally_and_finish;
      if (n_mismatch == 0 && n_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   initial begin
      // Whole run needs about 50000 cycles
      #3000000;
      n_mismatch++;
      tally_and_finish();
   end
   initial begin
      tick(2);
      rst_b = 1'h1;
      tick(1);
      chk(32'h3, alarm_group_seven);
      chk(32'h3FFF, {14'h0, fault_time_value});
      status_events = 32'h6;
      recovery_events = 32'hF;
      alarm7_events = 32'h10;
      tick(4);
      {status_events, recovery_events, alarm7_events} = '0;
      tick(5);
      wr(0, 32'h4);
      chk(32'h2, alarm_status_group_zero);
      wr(1, 32'hFFFFFFFB);
      chk(32'hB, recovery_miss_error_flags);
      chk(32'hF, recovery_status);
      wr(2, 32'hFFFFFFFB);
      chk(32'hB, recovery_status);
      wr(3, 32'h3);
      chk(32'h13, alarm_group_seven);
      hidden_src_clear = 1'h1;
      tick(3);
      wr(3, 32'h3);
      chk(32'h10, alarm_group_seven);
      for (int i = 0; i < 8; i++) begin
         core_enable = i[2];
         fault_signal_protocol = safety_monitor_pkg::protocol_type'(i[1:0]);
         tick(2);
         chk({31'h0, i[2] & i[1]}, {31'h0, core_off_detectable});
      end
      // System reset in mid-run raises the two alarms again
      rst_b = 1'h0;
      tick(2);
      rst_b = 1'h1;
      tick(1);
      chk(32'h3, alarm_group_seven);
      chk(32'h3FFF, {14'h0, fault_time_value});
      for (int h = 0; h < 2; h++) begin
         fault_time_high_field = 4'(h);
         tick(2);
         chk(32'h3FFF + 32'h4000 * h, {14'h0, fault_time_value});
         alarm_trigger = 1'h1;
         wr(0, 32'hFFFFFFFF);
         for (n = 0; fault_active !== 1'h1 && n < 9; n++) tick(1);
         alarm_trigger = 1'h0;
         for (n = 0; fault_active === 1'h1 && n < 40000; n++) tick(1);
         chk(32'h4000 * (h + 1), 32'(n));
      end
      tally_and_finish();
   end
endmodule
